// [logic/msg_master_end.sv]
// master node message layer: software builds orders over APB,
// the block sends them, polls while orders are open and collects replies
// assumes APB from a single master on clk; pready is always high
`timescale 1ns/100ps
module msg_master_end (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link toward the slave node
  msg_link_if.master_end link
);
  logic [7:0] tx_node_reg;
  logic [3:0] tx_src_reg;
  logic [3:0] tx_dst_reg;
  logic tx_se_reg;
  logic tx_de_reg;
  logic [7:0] tx_cmd_reg;
  logic [3:0] tx_cnt_reg;
  msg_pkg::msg_data_t tx_data_reg;
  msg_pkg::msg_buf_t rx_buf_reg;
  logic [4:0] rx_cnt_reg;
  logic rx_over_reg;
  logic rx_check_reg;
  logic rx_valid_reg;
  logic start_reg;
  logic refused_reg;
  logic timeout_reg;
  logic [31:0] to_limit_reg;
  logic [31:0] to_cnt_reg;
  logic [2:0] out_reg;
  logic [31:0] prdata_reg;

  logic wr;
  logic rd_setup;
  logic hit;
  logic [31:0] rd_mux;
  logic [3:0] win_idx;
  logic send_req;
  logic send_ok;
  logic tx_busy;
  logic tx_valid;
  logic tx_last;
  logic [4:0] tx_idx;
  logic tx_done;
  logic [7:0] tx_byte;
  logic [7:0] tx_len;
  logic rx_take;
  logic rx_end;
  logic [7:0] rx_len;
  logic rx_good;

  assign wr = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign win_idx = paddr[5:2];

  always_comb begin
    rd_mux = 32'h0000_0000;
    hit = 1'b1;
    case (paddr)
      msg_pkg::ADDR_CMD: rd_mux = 32'h0000_0000;
      msg_pkg::ADDR_STATUS: rd_mux = {21'h0, out_reg, 3'h0, timeout_reg, refused_reg,
        link.poll, rx_valid_reg, tx_busy || start_reg};
      msg_pkg::ADDR_TX_HDR: rd_mux = {tx_cmd_reg, 6'h00, tx_de_reg, tx_se_reg, tx_src_reg,
        tx_dst_reg, tx_node_reg};
      msg_pkg::ADDR_TX_CNT: rd_mux = {28'h0, tx_cnt_reg};
      msg_pkg::ADDR_RX_HDR: rd_mux = {rx_buf_reg[msg_pkg::POS_CMD], rx_buf_reg[msg_pkg::POS_TASK],
        rx_buf_reg[msg_pkg::POS_NODE], rx_buf_reg[msg_pkg::POS_FLAGS]};
      msg_pkg::ADDR_RX_LEN: rd_mux = {24'h0, rx_buf_reg[msg_pkg::POS_LEN]};
      msg_pkg::ADDR_TIMEOUT: rd_mux = to_limit_reg;
      default: begin
        hit = (paddr[1:0] == 2'h0) && (win_idx < 4'(msg_pkg::DATA_MAX))
          && ((paddr[7:6] == msg_pkg::WIN_TX_DATA) || (paddr[7:6] == msg_pkg::WIN_RX_DATA));
        if (hit && paddr[7:6] == msg_pkg::WIN_TX_DATA) begin
          rd_mux = {24'h0, tx_data_reg[win_idx]};
        end else if (hit) begin
          rd_mux = {24'h0, rx_buf_reg[5'(msg_pkg::HDR_BYTES) + {1'b0, win_idx}]};
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prdata_reg <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_reg <= rd_mux;
    end
  end
  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  // order registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_node_reg <= msg_pkg::NODE_MIN;
      tx_src_reg <= 4'h0;
      tx_dst_reg <= 4'h0;
      tx_se_reg <= 1'b0;
      tx_de_reg <= 1'b0;
      tx_cmd_reg <= 8'h00;
      tx_cnt_reg <= 4'h0;
      tx_data_reg <= '0;
      to_limit_reg <= 32'h0000_0000;
    end else if (wr) begin
      if (paddr == msg_pkg::ADDR_TX_HDR) begin
        tx_node_reg <= pwdata[msg_pkg::HDR_NODE_LSB +: 8];
        tx_dst_reg <= pwdata[msg_pkg::HDR_DST_LSB +: 4];
        tx_src_reg <= pwdata[msg_pkg::HDR_SRC_LSB +: 4];
        tx_se_reg <= pwdata[msg_pkg::HDR_SE];
        tx_de_reg <= pwdata[msg_pkg::HDR_DE];
        tx_cmd_reg <= pwdata[msg_pkg::HDR_CMD_LSB +: 8];
      end
      if (paddr == msg_pkg::ADDR_TX_CNT) begin
        // longer data would exceed what the slave accepts
        tx_cnt_reg <= (pwdata[3:0] > msg_pkg::DATA_MAX_CNT) ? msg_pkg::DATA_MAX_CNT
          : pwdata[3:0];
      end
      if (paddr == msg_pkg::ADDR_TIMEOUT) begin
        to_limit_reg <= pwdata;
      end
      if (hit && paddr[7:6] == msg_pkg::WIN_TX_DATA) begin
        tx_data_reg[win_idx] <= pwdata[7:0];
      end
    end
  end

  // send request: refused when busy, at the limit or to an invalid node
  assign send_req = wr && (paddr == msg_pkg::ADDR_CMD) && pwdata[msg_pkg::CMD_SEND];
  assign send_ok = !tx_busy && !start_reg && (out_reg != msg_pkg::OUT_MAX)
    && (tx_node_reg >= msg_pkg::NODE_MIN) && (tx_node_reg <= msg_pkg::NODE_MAX);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      start_reg <= 1'b0;
    end else begin
      start_reg <= send_req && send_ok;
    end
  end

  assign tx_len = {4'h0, tx_cnt_reg} + msg_pkg::LEN_OVERHEAD;

  always_comb begin
    case (tx_idx)
      5'h00: tx_byte = tx_len;
      5'h01: tx_byte = {1'b0, tx_se_reg, tx_de_reg, 1'b0, 4'h0};
      5'h02: tx_byte = tx_node_reg;
      5'h03: tx_byte = {tx_src_reg, tx_dst_reg};
      5'h04: tx_byte = tx_cmd_reg;
      default: tx_byte = tx_data_reg[4'(tx_idx - 5'h05)];
    endcase
  end

  msg_tx_seq u_tx_seq (
    .clk(clk),
    .reset(reset),
    .start(start_reg),
    .wire_len(tx_len - msg_pkg::WIRE_TRIM),
    .busy(tx_busy),
    .valid(tx_valid),
    .ready(link.m2s_ready),
    .last(tx_last),
    .idx(tx_idx)
  );

  assign link.m2s_valid = tx_valid;
  assign link.m2s_last = tx_last;
  assign link.m2s_data = tx_byte;
  assign tx_done = tx_valid && tx_last && link.m2s_ready;

  // reply reception, a good reply held until software releases it
  assign link.s2m_ready = !rx_valid_reg && !rx_check_reg;
  assign rx_take = link.s2m_valid && link.s2m_ready;
  assign rx_end = rx_take && link.s2m_last;
  assign rx_len = rx_buf_reg[msg_pkg::POS_LEN];
  assign rx_good = !rx_over_reg && (rx_cnt_reg >= 5'(msg_pkg::HDR_BYTES))
    && (rx_len >= msg_pkg::LEN_MIN) && (rx_len <= msg_pkg::LEN_MAX)
    && ({3'h0, rx_cnt_reg} == rx_len - msg_pkg::WIRE_TRIM)
    && rx_buf_reg[msg_pkg::POS_FLAGS][msg_pkg::MT_BIT]
    && (rx_buf_reg[msg_pkg::POS_NODE] >= msg_pkg::NODE_MIN)
    && (rx_buf_reg[msg_pkg::POS_NODE] <= msg_pkg::NODE_MAX);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_buf_reg <= '0;
      rx_cnt_reg <= 5'h00;
      rx_over_reg <= 1'b0;
      rx_check_reg <= 1'b0;
    end else begin
      rx_check_reg <= rx_end;
      if (rx_take) begin
        if (rx_cnt_reg < 5'(msg_pkg::BUF_BYTES)) begin
          rx_buf_reg[rx_cnt_reg] <= link.s2m_data;
          rx_cnt_reg <= rx_cnt_reg + 5'h01;
        end else begin
          rx_over_reg <= 1'b1;
        end
      end else if (rx_check_reg) begin
        rx_cnt_reg <= 5'h00;
        rx_over_reg <= 1'b0;
        rx_buf_reg[msg_pkg::POS_FLAGS][msg_pkg::TR_BIT] <= 1'b1;
      end
    end
  end

  // sticky flags, a set in the clearing cycle wins
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_valid_reg <= 1'b0;
      refused_reg <= 1'b0;
      timeout_reg <= 1'b0;
    end else begin
      if (rx_check_reg && rx_good) begin
        rx_valid_reg <= 1'b1;
      end else if (wr && paddr == msg_pkg::ADDR_STATUS && pwdata[msg_pkg::ST_RX_VALID]) begin
        rx_valid_reg <= 1'b0; // bad replies never set it
      end
      if (send_req && !send_ok) begin
        refused_reg <= 1'b1;
      end else if (wr && paddr == msg_pkg::ADDR_STATUS && pwdata[msg_pkg::ST_REFUSED]) begin
        refused_reg <= 1'b0;
      end
      if (to_limit_reg != 32'h0000_0000 && to_cnt_reg == to_limit_reg) begin
        timeout_reg <= 1'b1;
      end else if (wr && paddr == msg_pkg::ADDR_STATUS && pwdata[msg_pkg::ST_TIMEOUT]) begin
        timeout_reg <= 1'b0;
      end
    end
  end

  // reply wait timer, restarted by each reply message
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      to_cnt_reg <= 32'h0000_0000;
    end else if (out_reg == 3'h0 || rx_end || to_cnt_reg == to_limit_reg) begin
      to_cnt_reg <= 32'h0000_0000;
    end else begin
      to_cnt_reg <= to_cnt_reg + 32'h0000_0001;
    end
  end

  // orders sent minus reply messages seen
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      out_reg <= 3'h0;
    end else begin
      case ({tx_done, rx_end})
        2'b10: out_reg <= out_reg + 3'h1;
        2'b01: out_reg <= (out_reg == 3'h0) ? 3'h0 : out_reg - 3'h1;
        default: out_reg <= out_reg;
      endcase
    end
  end
  assign link.poll = (out_reg != 3'h0);
endmodule : msg_master_end

// [logic/msg_pkg.sv]
// constants and types shared by both ends of the order/reply message layer
// assumes byte-wide message streams, one byte per accepted handshake
package msg_pkg;
  // message geometry
  localparam int DATA_MAX = 13;
  localparam int HDR_BYTES = 5;
  localparam int BUF_BYTES = 18;
  localparam logic [7:0] LEN_OVERHEAD = 8'h07;
  localparam logic [7:0] LEN_MIN = 8'h07;
  localparam logic [7:0] LEN_MAX = 8'h14;
  localparam logic [7:0] WIRE_TRIM = 8'h02;
  localparam logic [3:0] DATA_MAX_CNT = 4'hD;
  // byte positions
  localparam int POS_LEN = 0;
  localparam int POS_FLAGS = 1;
  localparam int POS_NODE = 2;
  localparam int POS_TASK = 3;
  localparam int POS_CMD = 4;
  // flag byte bits
  localparam int MT_BIT = 7;
  localparam int SE_BIT = 6;
  localparam int DE_BIT = 5;
  localparam int TR_BIT = 4;
  // response codes
  localparam logic [7:0] RESP_OK = 8'h00;
  localparam logic [7:0] RESP_NO_TASK = 8'h80;
  localparam logic [7:0] RESP_PROTO = 8'h91;
  localparam logic [7:0] RESP_NO_DEV = 8'h93;
  // node address range
  localparam logic [7:0] NODE_MIN = 8'h01;
  localparam logic [7:0] NODE_MAX = 8'hFA;
  // outstanding message limit
  localparam logic [2:0] OUT_MAX = 3'h7;
  // controller register offsets
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_TX_HDR = 8'h08;
  localparam logic [7:0] ADDR_TX_CNT = 8'h0C;
  localparam logic [7:0] ADDR_RX_HDR = 8'h10;
  localparam logic [7:0] ADDR_RX_LEN = 8'h14;
  localparam logic [7:0] ADDR_TIMEOUT = 8'h18;
  localparam logic [1:0] WIN_TX_DATA = 2'h1;
  localparam logic [1:0] WIN_RX_DATA = 2'h2;
  // status and command bits
  localparam int CMD_SEND = 0;
  localparam int ST_BUSY = 0;
  localparam int ST_RX_VALID = 1;
  localparam int ST_POLL = 2;
  localparam int ST_REFUSED = 3;
  localparam int ST_TIMEOUT = 4;
  localparam int ST_OUT_LSB = 8;
  // tx header register fields
  localparam int HDR_NODE_LSB = 0;
  localparam int HDR_DST_LSB = 8;
  localparam int HDR_SRC_LSB = 12;
  localparam int HDR_SE = 16;
  localparam int HDR_DE = 17;
  localparam int HDR_CMD_LSB = 24;

  typedef logic [BUF_BYTES-1:0][7:0] msg_buf_t;
  typedef logic [DATA_MAX-1:0][7:0] msg_data_t;
endpackage : msg_pkg

// [logic/msg_link_if.sv]
// byte streams between master node and slave node message layers
// assumes the link layer below delivers whole messages in order per direction
`timescale 1ns/100ps
interface msg_link_if;
  logic m2s_valid;
  logic m2s_ready;
  logic [7:0] m2s_data;
  logic m2s_last;
  logic s2m_valid;
  logic s2m_ready;
  logic [7:0] s2m_data;
  logic s2m_last;
  logic poll;

  modport master_end (
    output m2s_valid, m2s_data, m2s_last, s2m_ready, poll,
    input m2s_ready, s2m_valid, s2m_data, s2m_last
  );
  modport slave_end (
    input m2s_valid, m2s_data, m2s_last, s2m_ready, poll,
    output m2s_ready, s2m_valid, s2m_data, s2m_last
  );
endinterface : msg_link_if

// [logic/msg_tx_seq.sv]
// byte sequencer: walks a buffer index over one outgoing message
// assumes the parent supplies the byte for idx and holds wire_len while busy
`timescale 1ns/100ps
module msg_tx_seq (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control
  input wire logic start,
  input wire logic [7:0] wire_len,
  output logic busy,
  // stream side
  output logic valid,
  input wire logic ready,
  output logic last,
  output logic [4:0] idx
);
  logic busy_reg;
  logic [4:0] idx_reg;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      busy_reg <= 1'b0;
      idx_reg <= 5'h00;
    end else if (start && !busy_reg) begin
      busy_reg <= 1'b1;
      idx_reg <= 5'h00;
    end else if (busy_reg && ready) begin
      if (last) begin
        busy_reg <= 1'b0;
      end else begin
        idx_reg <= idx_reg + 5'h01;
      end
    end
  end

  assign busy = busy_reg;
  assign valid = busy_reg;
  assign idx = idx_reg;
  assign last = busy_reg && ({3'h0, idx_reg} == wire_len - 8'h01);
endmodule : msg_tx_seq

// [logic/msg_slave_end.sv]
// slave node message layer: checks orders, hands them to tasks,
// turns failed orders into error replies and sends task replies when polled
// assumes the link below filters frames and that tasks keep order/reply pairing
`timescale 1ns/100ps
// Summary of operation
// - one reply per order, any order
// - master polls only with orders outstanding
// - refuse eighth outstanding message
// - failed order returns as error reply
// - reply with errors dropped silently
// - originating task times out missing replies
// - length equals data bytes plus seven
// - accept up to thirteen data bytes
// - never send longer than receiver accepts
// - all header fields present, data optional
// - type flag zero orders, one replies
// - source extension kept order to reply
// - destination extension kept order to reply
// - track sent zero, set on receive
// - reserved bits sent zero, ignored
// - node address valid one to 250
// - source task nibble names master task
// - destination task nibble names slave task
// - layer writes response only for errors
// - error codes 80H, 91H, 93H
// - header byte order length to data
module msg_slave_end (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // link toward the master node
  msg_link_if.slave_end link,
  // node configuration
  input wire logic [7:0] my_node_addr,
  input wire logic [15:0] task_present,
  input wire logic ext_present,
  input wire logic [15:0] ext_task_present,
  // orders to tasks
  output logic ord_valid,
  input wire logic ord_ready,
  output msg_pkg::msg_buf_t ord_msg,
  // replies from tasks
  input wire logic rep_valid,
  output logic rep_ready,
  input wire logic [3:0] rep_src_task,
  input wire logic [3:0] rep_dst_task,
  input wire logic rep_se,
  input wire logic rep_de,
  input wire logic [7:0] rep_response,
  input wire logic [3:0] rep_data_cnt,
  input wire msg_pkg::msg_data_t rep_data,
  // status
  output logic [2:0] outstanding
);
  typedef enum {RX_COLLECT, RX_CHECK, RX_HOLD, RX_CONVERT} rx_state_t;

  rx_state_t rx_state_reg;
  msg_pkg::msg_buf_t rx_buf_reg;
  msg_pkg::msg_buf_t tx_buf_reg;
  logic [4:0] rx_cnt_reg;
  logic rx_over_reg;
  logic [7:0] err_code_reg;
  logic err_short_reg;
  logic tx_loaded_reg;
  logic [2:0] out_reg;

  logic rx_take;
  logic tx_busy;
  logic tx_valid;
  logic tx_last;
  logic [4:0] tx_idx;
  logic tx_done;
  logic tx_start;
  logic convert_now;
  logic rep_take;
  logic [7:0] rx_len;
  logic [7:0] rx_flags;
  logic [3:0] rx_dst;
  logic len_ok;
  logic mine;
  logic task_ok;
  logic [7:0] check_code;
  logic [3:0] rep_cnt;

  // a new message is taken only below the outstanding limit
  assign link.m2s_ready = (rx_state_reg == RX_COLLECT) && (out_reg != msg_pkg::OUT_MAX);
  assign rx_take = link.m2s_valid && link.m2s_ready;

  assign rx_len = rx_buf_reg[msg_pkg::POS_LEN];
  assign rx_flags = rx_buf_reg[msg_pkg::POS_FLAGS];
  assign rx_dst = rx_buf_reg[msg_pkg::POS_TASK][3:0];
  // length range, data bound and byte count must all agree
  assign len_ok = (rx_len >= msg_pkg::LEN_MIN) && (rx_len <= msg_pkg::LEN_MAX) && !rx_over_reg
    && ({3'h0, rx_cnt_reg} == rx_len - msg_pkg::WIRE_TRIM);
  // too short for a header, or for another node: nothing to answer
  assign mine = (rx_cnt_reg >= 5'(msg_pkg::HDR_BYTES))
    && (rx_buf_reg[msg_pkg::POS_NODE] == my_node_addr);
  assign task_ok = rx_flags[msg_pkg::DE_BIT] ? ext_task_present[rx_dst] : task_present[rx_dst];

  always_comb begin
    if (!len_ok || rx_flags[msg_pkg::MT_BIT]) begin
      check_code = msg_pkg::RESP_PROTO;
    end else if (rx_flags[msg_pkg::DE_BIT] && !ext_present) begin
      check_code = msg_pkg::RESP_NO_DEV;
    end else if (!task_ok) begin
      check_code = msg_pkg::RESP_NO_TASK;
    end else begin
      check_code = msg_pkg::RESP_OK;
    end
  end

  // receive state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_state_reg <= RX_COLLECT;
    end else begin
      case (rx_state_reg)
        RX_COLLECT: begin
          if (rx_take && link.m2s_last) begin
            rx_state_reg <= RX_CHECK;
          end
        end
        RX_CHECK: begin
          if (!mine) begin
            rx_state_reg <= RX_COLLECT;
          end else if (check_code == msg_pkg::RESP_OK) begin
            rx_state_reg <= RX_HOLD;
          end else begin
            rx_state_reg <= RX_CONVERT;
          end
        end
        RX_HOLD: begin
          if (ord_ready) begin
            rx_state_reg <= RX_COLLECT;
          end
        end
        RX_CONVERT: begin
          if (convert_now) begin
            rx_state_reg <= RX_COLLECT;
          end
        end
        default: begin
          rx_state_reg <= RX_COLLECT;
        end
      endcase
    end
  end

  // receive buffer, bytes past the buffer only mark overflow
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_buf_reg <= '0;
      rx_cnt_reg <= 5'h00;
      rx_over_reg <= 1'b0;
    end else if (rx_take) begin
      if (rx_cnt_reg < 5'(msg_pkg::BUF_BYTES)) begin
        rx_buf_reg[rx_cnt_reg] <= link.m2s_data;
        rx_cnt_reg <= rx_cnt_reg + 5'h01;
      end else begin
        rx_over_reg <= 1'b1;
      end
    end else if (rx_state_reg == RX_CHECK) begin
      rx_cnt_reg <= 5'h00;
      rx_over_reg <= 1'b0;
    end
  end

  // error classification held for the conversion
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      err_code_reg <= msg_pkg::RESP_OK;
      err_short_reg <= 1'b0;
    end else if (rx_state_reg == RX_CHECK) begin
      err_code_reg <= check_code;
      err_short_reg <= !len_ok;
    end
  end

  // order to task, track forced on reception
  always_comb begin
    ord_msg = rx_buf_reg;
    ord_msg[msg_pkg::POS_FLAGS][msg_pkg::TR_BIT] = 1'b1;
  end
  assign ord_valid = (rx_state_reg == RX_HOLD);

  // error conversion takes the reply buffer ahead of task replies
  assign convert_now = (rx_state_reg == RX_CONVERT) && !tx_loaded_reg;
  assign rep_ready = !tx_loaded_reg && (rx_state_reg != RX_CONVERT);
  assign rep_take = rep_valid && rep_ready;
  assign rep_cnt = (rep_data_cnt > msg_pkg::DATA_MAX_CNT) ? msg_pkg::DATA_MAX_CNT : rep_data_cnt;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_buf_reg <= '0;
    end else if (convert_now) begin
      // same order back, only type, track, reserved, response and, after a bad length, the length byte change
      tx_buf_reg <= rx_buf_reg;
      tx_buf_reg[msg_pkg::POS_FLAGS] <= {1'b1, rx_flags[msg_pkg::SE_BIT],
        rx_flags[msg_pkg::DE_BIT], 1'b0, 4'h0};
      tx_buf_reg[msg_pkg::POS_CMD] <= err_code_reg;
      if (err_short_reg) begin
        tx_buf_reg[msg_pkg::POS_LEN] <= msg_pkg::LEN_MIN;
      end
    end else if (rep_take) begin
      tx_buf_reg[msg_pkg::POS_LEN] <= {4'h0, rep_cnt} + msg_pkg::LEN_OVERHEAD;
      tx_buf_reg[msg_pkg::POS_FLAGS] <= {1'b1, rep_se, rep_de, 1'b0, 4'h0};
      tx_buf_reg[msg_pkg::POS_NODE] <= my_node_addr;
      tx_buf_reg[msg_pkg::POS_TASK] <= {rep_src_task, rep_dst_task};
      tx_buf_reg[msg_pkg::POS_CMD] <= rep_response;
      for (int i = 0; i < msg_pkg::DATA_MAX; i++) begin
        tx_buf_reg[msg_pkg::HDR_BYTES + i] <= rep_data[i];
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_loaded_reg <= 1'b0;
    end else if (convert_now || rep_take) begin
      tx_loaded_reg <= 1'b1;
    end else if (tx_done) begin
      tx_loaded_reg <= 1'b0;
    end
  end

  // replies leave only while the master polls
  assign tx_start = tx_loaded_reg && !tx_busy && link.poll;
  assign tx_done = tx_valid && tx_last && link.s2m_ready;

  msg_tx_seq u_tx_seq (
    .clk(clk),
    .reset(reset),
    .start(tx_start),
    .wire_len(tx_buf_reg[msg_pkg::POS_LEN] - msg_pkg::WIRE_TRIM),
    .busy(tx_busy),
    .valid(tx_valid),
    .ready(link.s2m_ready),
    .last(tx_last),
    .idx(tx_idx)
  );

  assign link.s2m_valid = tx_valid;
  assign link.s2m_last = tx_last;
  assign link.s2m_data = tx_buf_reg[tx_idx];

  // messages for this node minus replies sent
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      out_reg <= 3'h0;
    end else begin
      case ({(rx_state_reg == RX_CHECK) && mine, tx_done})
        2'b10: out_reg <= out_reg + 3'h1;
        2'b01: out_reg <= out_reg - 3'h1;
        default: out_reg <= out_reg;
      endcase
    end
  end
  assign outstanding = out_reg;
endmodule : msg_slave_end

// [dv/order_reply_message_framer_sva.sv]
// wire checks on the order and reply byte streams
// assumes both ends share clk and reset
`timescale 1ns/100ps
module order_reply_message_framer_sva (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // orders
  input wire logic m2s_valid,
  input wire logic m2s_ready,
  input wire logic [7:0] m2s_data,
  input wire logic m2s_last,
  // replies
  input wire logic s2m_valid,
  input wire logic s2m_ready,
  input wire logic [7:0] s2m_data,
  input wire logic s2m_last,
  input wire logic poll
);
  logic [7:0] mi_reg;
  logic [7:0] si_reg;
  logic [7:0] ml_reg;
  wire mt = m2s_valid && m2s_ready;
  wire st = s2m_valid && s2m_ready;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // byte index within the current message
  always_ff @(posedge clk or posedge reset)
    if (reset) mi_reg <= 8'h00;
    else if (mt) mi_reg <= m2s_last ? 8'h00 : mi_reg + 8'h01;
  always_ff @(posedge clk or posedge reset)
    if (reset) si_reg <= 8'h00;
    else if (st) si_reg <= s2m_last ? 8'h00 : si_reg + 8'h01;
  always_ff @(posedge clk or posedge reset)
    if (reset) ml_reg <= 8'h00;
    else if (mt && mi_reg == 8'h00) ml_reg <= m2s_data;
  property p_m_type; mt && mi_reg == 8'h01 |-> !m2s_data[7]; endproperty
  a_m_type: assert property (p_m_type) else $error("order type flag set");
  property p_s_type; st && si_reg == 8'h01 |-> s2m_data[7]; endproperty
  a_s_type: assert property (p_s_type) else $error("reply type flag clear");
  property p_m_low; mt && mi_reg == 8'h01 |-> m2s_data[4:0] == 5'h00; endproperty
  a_m_low: assert property (p_m_low) else $error("order low flags set");
  property p_s_low; st && si_reg == 8'h01 |-> s2m_data[4:0] == 5'h00; endproperty
  a_s_low: assert property (p_s_low) else $error("reply low flags set");
  property p_node; mt && mi_reg == 8'h02 |-> m2s_data inside {[8'h01:8'hFA]}; endproperty
  a_node: assert property (p_node) else $error("order node out of range");
  property p_m_last; mt && m2s_last |-> mi_reg == ml_reg - 8'h03; endproperty
  a_m_last: assert property (p_m_last) else $error("order byte count off");
  property p_s_len; st && si_reg == 8'h00 |-> s2m_data inside {[8'h07:8'h14]}; endproperty
  a_s_len: assert property (p_s_len) else $error("reply length bad");
  property p_poll; st && si_reg == 8'h00 |-> poll; endproperty
  a_poll: assert property (p_poll) else $error("reply sent unpolled");
endmodule : order_reply_message_framer_sva

// [dv/order_reply_message_framer_test.sv]
// bench joining both message layer ends through the link interface
// assumes the design files under logic are compiled first
`timescale 1ns/100ps
module order_reply_message_framer_test;
  typedef struct packed {logic [3:0] src; logic [3:0] dst; logic se; logic de;
    logic [3:0] cnt; logic [7:0] code;} row_t;
  row_t rows [4] = '{'{4'h2, 4'h1, 1'b1, 1'b0, 4'hD, 8'h00},
    '{4'h3, 4'h4, 1'b0, 1'b0, 4'h0, 8'h80},
    '{4'hF, 4'h0, 1'b1, 1'b1, 4'h2, 8'h93}, '{4'h0, 4'h0, 1'b0, 1'b0, 4'h0, 8'h00}};
  row_t r;
  logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, ord_ready = 0, rep_valid = 0;
  logic pready, pslverr, ord_valid, rep_ready, rse = 0, rde = 0;
  logic [7:0] paddr = 8'h00;
  logic [3:0] rsrc = 0, rdst = 0, rcnt = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic [2:0] outstanding;
  msg_pkg::msg_buf_t ord_msg;
  msg_pkg::msg_data_t rdata = '0;
  int errors = 0, checks = 0, n;
  msg_link_if link ();
  msg_master_end msg_master_end_inst (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  msg_slave_end msg_slave_end_inst (.clk(clk), .reset(reset), .link(link), .my_node_addr(8'h05),
    .task_present(16'h0003), .ext_present(1'b0), .ext_task_present(16'h0001),
    .ord_valid(ord_valid), .ord_ready(ord_ready), .ord_msg(ord_msg), .rep_valid(rep_valid),
    .rep_ready(rep_ready), .rep_src_task(rsrc), .rep_dst_task(rdst), .rep_se(rse), .rep_de(rde),
    .rep_response(8'h00), .rep_data_cnt(rcnt), .rep_data(rdata), .outstanding(outstanding));
  order_reply_message_framer_sva order_reply_message_framer_sva_inst (.clk(clk), .reset(reset),
    .m2s_valid(link.m2s_valid), .m2s_ready(link.m2s_ready), .m2s_data(link.m2s_data),
    .m2s_last(link.m2s_last), .s2m_valid(link.s2m_valid), .s2m_ready(link.s2m_ready),
    .s2m_data(link.s2m_data), .s2m_last(link.s2m_last), .poll(link.poll));
  initial forever #12.5 clk = ~clk;
  task stop_test;
    if (errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task tmo(input logic hit);
    if (hit) begin
      errors++;
      stop_test();
    end
  endtask : tmo
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    for (k = 0; pready !== 1'b1 && k < 50; k++) @(posedge clk);
    tmo(k == 50);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    apb(0, msg_pkg::ADDR_STATUS, 0);
    chk(q, 0);
    foreach (rows[i]) begin
      r = rows[i];
      apb(1, msg_pkg::ADDR_TX_HDR, {8'h3C, 6'h00, r.de, r.se, r.src, r.dst, 8'h05});
      apb(1, msg_pkg::ADDR_TX_CNT, {28'h0, r.cnt});
      apb(1, msg_pkg::ADDR_CMD, 32'h1);
      if (r.code == 8'h00) begin
        for (n = 0; ord_valid !== 1'b1 && n < 900; n++) @(negedge clk);
        tmo(n == 900);
        chk(ord_msg[0], 8'h07 + r.cnt);
        chk({ord_msg[1][7:4], ord_msg[3]}, {1'b0, r.se, r.de, 1'b1, r.src, r.dst});
        chk(outstanding, 1);
        @(posedge clk) ord_ready <= 1'b1;
        @(posedge clk) ord_ready <= 1'b0;
        rep_valid <= 1'b1;
        {rsrc, rdst, rse, rde, rcnt} <= {r.src, r.dst, r.se, r.de, r.cnt};
        rdata <= {13{r.src, r.dst}};
        for (n = 0; rep_ready !== 1'b1 && n < 900; n++) @(negedge clk);
        tmo(n == 900);
        @(posedge clk) rep_valid <= 1'b0;
      end
      n = 0;
      do begin
        apb(0, msg_pkg::ADDR_STATUS, 0);
        n++;
      end while (q[1] !== 1'b1 && n < 300);
      tmo(n == 300);
      apb(0, msg_pkg::ADDR_RX_HDR, 0);
      chk(q & 32'hFFFFFFF0, {r.code, r.src, r.dst, 8'h05, 1'b1, r.se, r.de, 5'h10});
      apb(0, msg_pkg::ADDR_RX_LEN, 0);
      chk(q, 32'h7 + r.cnt);
      apb(1, msg_pkg::ADDR_STATUS, 32'h2);
      chk(link.poll, 0);
      chk(outstanding, 0);
    end
    apb(1, msg_pkg::ADDR_TX_HDR, 32'h00000000);
    apb(1, msg_pkg::ADDR_CMD, 32'h1);
    apb(0, msg_pkg::ADDR_STATUS, 0);
    chk(q[3:0], 4'h8);
    // order to a foreign node: no reply ever comes, the reply wait timer must fire
    apb(1, msg_pkg::ADDR_TIMEOUT, 32'h14);
    apb(1, msg_pkg::ADDR_TX_HDR, 32'h6);
    apb(1, msg_pkg::ADDR_CMD, 32'h1);
    repeat (40) @(posedge clk);
    apb(0, msg_pkg::ADDR_STATUS, 0);
    chk(q, 32'h11C);
    chk(outstanding, 0);
    stop_test();
  end
endmodule : order_reply_message_framer_test
